/* File: line_printer_sync.sv */
// printer synchronizer: command, paper, fetch, drum, hammers
// Operation
// - fetch 32 consecutive words, check each mod 3
// - ignore sign bit, use character fields
// - decode zone+numeric; nonprinting codes never strike
// - track drum row at printing position
// - strike every column matching drum row
// - line done when all printable struck
// - first line advance takes 10 ms
// - further lines 8.3 or 6.25 ms
// - settle 10 ms after paper moves, before any strike
// - low paper signals processor with interrupt
// - runaway over 1.5 s stops paper, alerts
// - take command after line, clear interlock
// - command error sets data error and interlock
// - load words during advance, print afterwards
// - completion with interrupt bit sets completion
// - fault during printing sets fault, interrupts
// - completion set blocks resetting and fetching
// - bit 18 prints or only advances
// - completion interrupt only when bit 16
// - bits 1-15 start address, 32 words
// - data error interrupts, stops memory access
// - low paper stops memory access until cleared
`timescale 1ns/1ps
module line_printer_sync
   import line_printer_sync_pkg::*;
#(
   parameter int FIRST_CNT   = FIRST_CYC,
   parameter int LINE6_CNT   = LINE6_CYC,
   parameter int LINE8_CNT   = LINE8_CYC,
   parameter int SETTLE_CNT  = SETTLE_CYC,
   parameter int RUNAWAY_CNT = RUNAWAY_CYC
) (
   // clock, reset, enable
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   // axi4-lite slave
   input  wire logic [7:0]   awaddr,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   input  wire logic [7:0]   araddr,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   // memory read channel
   output logic              memReq,
   output logic [14:0]       memAddr,
   input  wire logic         memAck,
   input  wire logic [26:0]  memData,
   input  wire logic         memAddrErr,
   // printer pins
   input  wire logic         drumIndexPin,
   input  wire logic         drumRowPin,
   input  wire logic         eightLpiPin,
   input  wire logic         lowPaperPin,
   input  wire logic         faultPin,
   input  wire logic         paperMovingPin,
   output logic              paperDrive,
   output logic [127:0]      hammerFire,
   output logic              irq
);
   localparam int CW = 28;
   // counts must fit the timer and never be zero
   if (FIRST_CNT < 1 || LINE6_CNT < 1 || LINE8_CNT < 1 || SETTLE_CNT < 1 ||
       RUNAWAY_CNT < 1 || RUNAWAY_CNT >= 2**CW || FIRST_CNT >= 2**CW ||
       SETTLE_CNT >= 2**CW || LINE6_CNT >= 2**CW || LINE8_CNT >= 2**CW)
      $error("line_printer_sync: timing count out of range");
   typedef enum {IDLE, ADVANCE, SETTLE, PRINT, FINISH} state_t;
   // remainder of a value by three
   function automatic logic [1:0] mod3(input logic [24:0] v);
      return 2'(v % 25'd3);
   endfunction
   // true for codes that put ink on paper
   function automatic logic strikes(input logic [5:0] c);
      return !(c == 6'h00 || c == 6'h20 || c == 6'h30 || c == 6'h13 || c == 6'h23 ||
               (c[5] && c[3:0] >= 4'hD) || (c[5:4] == 2'b01 && c[3:0] >= 4'hE));
   endfunction
   state_t      state_reg;
   logic [26:0] cmd_reg;
   logic        standby_reg, done_reg, derr_reg, fault_reg, lowp_reg, enable_reg;
   logic [5:0]  linesLeft_reg, fetchIdx_reg, row_reg, pinMeta, pinSync, pinLast;
   logic        doPrint_reg, wantIrq_reg, moved_reg;
   logic [CW-1:0] timer_reg, runCnt_reg;
   logic        paperDrive_reg, memReq_reg, irq_reg, strikeNow_reg, arready_reg, rvalid_reg;
   logic [14:0] memAddr_reg;
   logic [5:0]  lineChars [LINE_COLS];
   logic [127:0] pending_reg, hammer_reg;
   // axi state
   logic        awready_reg, wready_reg, bvalid_reg, awHeld_reg, wHeld_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [7:0]  awAddr_reg;
   logic [31:0] wData_reg, rdata_reg;
   logic [3:0]  wStrb_reg;
   // pin sync: meta feeds only the sync stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pinMeta <= 6'h00;
         pinSync <= 6'h00;
         pinLast <= 6'h00;
      end else if (ce) begin
         pinMeta <= {paperMovingPin, faultPin, lowPaperPin,
                     eightLpiPin, drumIndexPin, drumRowPin};
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end
   // synced pin levels and drum edges
   wire rowEdge   = pinSync[0] & ~pinLast[0];
   wire indexEdge = pinSync[1] & ~pinLast[1];
   wire eightLpi  = pinSync[2];
   wire lowPaper  = pinSync[3];
   wire faultIn   = pinSync[4];
   wire moving    = pinSync[5];
   // command decode and word checks
   wire fsBad    = mod3(cmd_reg[24:0]) != cmd_reg[26:WD_CHECK_LO];
   wire [5:0] fsLines = cmd_reg[FS_LINES_LO +: 6];
   wire fsPrint  = cmd_reg[FS_PRINT];
   wire fsIrq    = cmd_reg[FS_IRQ];
   wire [14:0] fsAddr = cmd_reg[FS_ADDR_LO +: 15];
   wire busy     = state_reg != IDLE;
   // held indicators block any further memory traffic
   wire blocked  = done_reg | derr_reg | fault_reg | lowp_reg;
   wire take     = !busy && standby_reg && enable_reg && !blocked;
   wire wordIn   = memReq_reg && memAck;
   wire wordBad  = memAddrErr ||
                   mod3(memData[24:0]) != memData[26:WD_CHECK_LO];
   wire runaway  = runCnt_reg == CW'(RUNAWAY_CNT);
   wire derrSet  = (take && fsBad) || (busy && wordIn && wordBad);
   wire faultSet = !derrSet && busy && (faultIn || runaway);
   wire finish   = state_reg == FINISH;
   wire doneSet  = finish && wantIrq_reg && !done_reg;
   wire lowpSet  = finish && lowPaper;
   wire abort    = derrSet || faultSet;
   wire fetched  = fetchIdx_reg == 6'(LINE_WORDS);
   wire [CW-1:0] perLine = eightLpi ? CW'(LINE8_CNT - 1) : CW'(LINE6_CNT - 1);
   // columns whose character is under the hammer now
   wire [5:0] drumCode = DRUM_CODES[row_reg];
   logic [127:0] hit;
   for (genvar c = 0; c < LINE_COLS; c++) begin : g_col
      assign hit[c] = pending_reg[c] && lineChars[c] == drumCode;
   end
   wire striking = state_reg == PRINT && strikeNow_reg;
   // drum row tracking from index and row pulses
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         row_reg <= 6'h00;
         strikeNow_reg <= 1'b0;
      end else if (ce) begin
         if (indexEdge)
            row_reg <= 6'h00;
         else if (rowEdge)
            row_reg <= (row_reg == 6'(DRUM_ROWS - 1)) ? 6'h00 : row_reg + 6'h01;
         strikeNow_reg <= indexEdge | rowEdge;
      end
   end
   // hammers fire one cycle per row step; flags stop restrikes
   always_ff @(posedge clk_sys) begin
      if (rst)
         hammer_reg <= '0;
      else if (ce)
         hammer_reg <= striking ? hit : '0;
   end
   // line store: chars and per-column pending strike flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pending_reg <= '0;
      end else if (ce) begin
         if (take)
            pending_reg <= '0;
         else if (striking)
            pending_reg <= pending_reg & ~hit;
         if (busy && wordIn && !wordBad) begin
            for (int k = 0; k < 4; k++) begin
               // sign bit 24 is not used for characters, only in the mod 3 check
               lineChars[{fetchIdx_reg[4:0], 2'(k)}] <= memData[23 - 6*k -: 6];
               pending_reg[{fetchIdx_reg[4:0], 2'(k)}] <=
                  strikes(memData[23 - 6*k -: 6]);
            end
         end
      end
   end
   // word fetch runs alongside the paper advance
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         memReq_reg <= 1'b0;
         memAddr_reg <= 15'h0000;
         fetchIdx_reg <= 6'h00;
      end else if (ce) begin
         if (abort) begin
            memReq_reg <= 1'b0;
         end else if (take) begin
            memReq_reg <= fsPrint;
            memAddr_reg <= fsAddr;
            fetchIdx_reg <= 6'h00;
         end else if (busy && wordIn) begin
            fetchIdx_reg <= fetchIdx_reg + 6'h01;
            memAddr_reg <= memAddr_reg + 15'h0001;
            if (fetchIdx_reg == 6'(LINE_WORDS - 1))
               memReq_reg <= 1'b0;
         end
      end
   end
   // runaway watch on continuous paper motion
   always_ff @(posedge clk_sys) begin
      if (rst)
         runCnt_reg <= '0;
      else if (ce)
         runCnt_reg <= (paperDrive_reg || moving) && !runaway ?
                       runCnt_reg + CW'(1) : '0;
   end
   // sequencer: advance, settle, print, finish
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= IDLE;
         paperDrive_reg <= 1'b0;
      end else if (ce) begin
         if (abort) begin
            // a runaway or error stops the paper at once
            state_reg <= IDLE;
            paperDrive_reg <= 1'b0;
         end else begin
            case (state_reg)
               IDLE: begin
                  if (take && !fsBad) begin
                     state_reg <= ADVANCE;
                     linesLeft_reg <= fsLines;
                     doPrint_reg <= fsPrint;
                     wantIrq_reg <= fsIrq;
                     moved_reg <= fsLines != 6'h00;
                     paperDrive_reg <= fsLines != 6'h00;
                     timer_reg <= CW'(FIRST_CNT - 1);
                  end
               end
               ADVANCE: begin
                  if (!moved_reg || (timer_reg == '0 && linesLeft_reg <= 6'h01)) begin
                     state_reg <= SETTLE;
                     linesLeft_reg <= 6'h00;
                     paperDrive_reg <= 1'b0;
                     timer_reg <= moved_reg ? CW'(SETTLE_CNT - 1) : '0;
                  end else if (timer_reg == '0) begin
                     linesLeft_reg <= linesLeft_reg - 6'h01;
                     timer_reg <= perLine;
                  end else begin
                     timer_reg <= timer_reg - CW'(1);
                  end
               end
               SETTLE: begin
                  if (timer_reg != '0)
                     timer_reg <= timer_reg - CW'(1);
                  else if (!doPrint_reg)
                     state_reg <= FINISH;
                  else if (fetched)
                     state_reg <= PRINT;
               end
               PRINT: begin
                  if (pending_reg == '0)
                     state_reg <= FINISH;
               end
               FINISH: state_reg <= IDLE;
               default: state_reg <= IDLE;
            endcase
         end
      end
   end
   // axi decode: write side
   wire [31:0] byteMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                           {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
   wire wrGo     = awHeld_reg && wHeld_reg && !bvalid_reg;
   wire wrCmd    = wrGo && awAddr_reg == OFS_CMD;
   wire wrStatus = wrGo && awAddr_reg == OFS_STATUS && wStrb_reg[0];
   wire wrCtrl   = wrGo && awAddr_reg == OFS_CTRL && wStrb_reg[0];
   wire wrMapped = awAddr_reg == OFS_CMD || awAddr_reg == OFS_STATUS ||
                   awAddr_reg == OFS_CTRL || awAddr_reg == OFS_DRUM;
   wire [26:0] cmdMerged = 27'((cmd_reg & ~byteMask[26:0]) |
                               (wData_reg[26:0] & byteMask[26:0]));
   wire [3:0] clrBits = wrStatus ? wData_reg[3:0] : 4'h0;
   wire wrCmdAny = wrCmd && wStrb_reg != 4'h0;
   // indicators: hardware set wins over software clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd_reg <= CMD_RST;
         enable_reg <= CTRL_RST;
         standby_reg <= 1'b0;
         done_reg <= 1'b0;
         derr_reg <= 1'b0;
         fault_reg <= 1'b0;
         lowp_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (ce) begin
         if (wrCmd)
            cmd_reg <= cmdMerged;
         if (wrCtrl)
            enable_reg <= wData_reg[0];
         if (wrCmdAny || derrSet)
            standby_reg <= 1'b1;
         else if (take)
            standby_reg <= 1'b0;
         done_reg  <= doneSet  | (done_reg  & ~clrBits[SB_DONE]);
         derr_reg  <= derrSet  | (derr_reg  & ~clrBits[SB_DERR]);
         fault_reg <= faultSet | (fault_reg & ~clrBits[SB_FAULT]);
         lowp_reg  <= lowpSet  | (lowp_reg  & ~clrBits[SB_LOWP]);
         irq_reg   <= derrSet | faultSet | doneSet | lowpSet;
      end
   end
   // axi write channels, either order, response after both
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         bvalid_reg <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready_reg) begin
            awAddr_reg <= awaddr;
            awHeld_reg <= 1'b1;
            awready_reg <= 1'b0;
         end
         if (wvalid && wready_reg) begin
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
            wHeld_reg <= 1'b1;
            wready_reg <= 1'b0;
         end
         if (wrGo) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wrMapped ? 2'b00 : 2'b10;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
         end
         if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end
   // axi read decode
   wire [31:0] statusWord = {25'h0000000, paperDrive_reg, busy, standby_reg,
                             lowp_reg, fault_reg, derr_reg, done_reg};
   wire [31:0] drumWord = {18'h00000, fetchIdx_reg, 2'b00, row_reg};
   wire rdCmd    = araddr == OFS_CMD;
   wire rdStatus = araddr == OFS_STATUS;
   wire rdCtrl   = araddr == OFS_CTRL;
   wire rdDrum   = araddr == OFS_DRUM;
   wire [31:0] rdMux = rdCmd    ? {5'h00, cmd_reg} :
                       rdStatus ? statusWord :
                       rdCtrl   ? {31'h00000000, enable_reg} :
                       rdDrum   ? drumWord : 32'h00000000;
   // axi read channel, one transfer at a time
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rdMux;
            rresp_reg <= (rdCmd | rdStatus | rdCtrl | rdDrum) ? 2'b00 : 2'b10;
         end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end
   // outputs straight from flops
   assign awready    = awready_reg;
   assign wready     = wready_reg;
   assign bvalid     = bvalid_reg;
   assign bresp      = bresp_reg;
   assign arready    = arready_reg;
   assign rvalid     = rvalid_reg;
   assign rdata      = rdata_reg;
   assign rresp      = rresp_reg;
   assign memReq     = memReq_reg;
   assign memAddr    = memAddr_reg;
   assign paperDrive = paperDrive_reg;
   assign hammerFire = hammer_reg;
   assign irq        = irq_reg;
endmodule

/* File: line_printer_sync_pkg.sv */
// constants for the drum line printer synchronizer
package line_printer_sync_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_DRUM   = 8'h0C;
   // status bit positions
   localparam int SB_DONE  = 0;
   localparam int SB_DERR  = 1;
   localparam int SB_FAULT = 2;
   localparam int SB_LOWP  = 3;
   localparam int SB_STBY  = 4;
   localparam int SB_BUSY  = 5;
   localparam int SB_PAPER = 6;
   // function_spec_word fields, bit n of the word sits at index n-1
   localparam int FS_LINES_LO = 18;
   localparam int FS_PRINT    = 17;
   localparam int FS_IRQ      = 15;
   localparam int FS_ADDR_LO  = 0;
   // stored word: check pair above sign above four 6-bit characters
   localparam int WD_CHECK_LO = 25;
   localparam int WD_SIGN     = 24;
   // reset values
   localparam logic [26:0] CMD_RST  = 27'h0000000;
   localparam logic        CTRL_RST = 1'b0;
   // line geometry
   localparam int LINE_WORDS = 32;
   localparam int LINE_COLS  = 128;
   localparam int DRUM_ROWS  = 51;
   // paper timing in microseconds, clock period in nanoseconds
   localparam int CLK_NS      = 10;
   localparam int FIRST_US    = 10000;
   localparam int LINE6_US    = 8300;
   localparam int LINE8_US    = 6250;
   localparam int SETTLE_US   = 10000;
   localparam int RUNAWAY_US  = 1500000;
   localparam int FIRST_CYC   = FIRST_US * 1000 / CLK_NS;
   localparam int LINE6_CYC   = LINE6_US * 1000 / CLK_NS;
   localparam int LINE8_CYC   = LINE8_US * 1000 / CLK_NS;
   localparam int SETTLE_CYC  = SETTLE_US * 1000 / CLK_NS;
   localparam int RUNAWAY_CYC = RUNAWAY_US * 1000 / CLK_NS;
   // character code of each drum row, row 0 first
   localparam logic [5:0] DRUM_CODES [DRUM_ROWS] = '{
      6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
      6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12,
      6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C,
      6'h1D, 6'h21, 6'h22, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29,
      6'h2A, 6'h2B, 6'h2C, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36,
      6'h37, 6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C};
endpackage

/* File: line_printer_sync_asserts.sv */
// port checker for the line printer synchronizer
`timescale 1ns/1ps
module line_printer_sync_asserts #(
   parameter int SETTLE_CNT  = 20,
   parameter int RUNAWAY_CNT = 5000
) (
   // clock and reset
   input wire logic         clk_sys,
   input wire logic         rst,
   // register bus handshakes
   input wire logic         awvalid,
   input wire logic         awready,
   input wire logic         wvalid,
   input wire logic         wready,
   input wire logic         bvalid,
   input wire logic         arvalid,
   input wire logic         arready,
   input wire logic         rvalid,
   // memory channel and printer
   input wire logic         memReq,
   input wire logic [14:0]  memAddr,
   input wire logic         memAck,
   input wire logic         paperDrive,
   input wire logic [127:0] hammerFire,
   input wire logic         irq
);
   int sinceDrive;
   int driveRun;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // cycles since paper stopped; length of drive run
   always_ff @(posedge clk_sys) begin
      if (rst) sinceDrive <= SETTLE_CNT;
      else if (paperDrive) sinceDrive <= 0;
      else if (sinceDrive < SETTLE_CNT) sinceDrive <= sinceDrive + 1;
      driveRun <= (rst || !paperDrive) ? 0 : driveRun + 1;
   end
   a_settle_wait: assert property (hammerFire != 128'h0 |-> sinceDrive >= SETTLE_CNT)
      else $error("strike before paper settled");
   a_strike_still: assert property (hammerFire != 128'h0 |-> !paperDrive)
      else $error("strike while paper driven");
   a_runaway_cut: assert property (driveRun <= RUNAWAY_CNT)
      else $error("paper drive ran too long");
   a_mem_hold: assert property ((memReq && !memAck) ##1 memReq |-> $stable(memAddr))
      else $error("address moved while waiting");
   a_addr_step: assert property ((memReq && memAck) ##1 memReq |->
      memAddr == $past(memAddr) + 15'h1) else $error("address not consecutive");
   a_hammer_pulse: assert property (hammerFire != 128'h0 |=>
      (hammerFire & $past(hammerFire)) == 128'h0) else $error("column struck twice");
   a_irq_pulse: assert property (irq |=> !irq)
      else $error("irq too long");
   a_b_after: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response late or early");
   a_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   c_strike: cover property (hammerFire != 128'h0);
   c_word: cover property (memReq && memAck);
   c_irq: cover property (irq);
endmodule
bind line_printer_sync line_printer_sync_asserts #(
   .SETTLE_CNT(SETTLE_CNT), .RUNAWAY_CNT(RUNAWAY_CNT)
) i_line_printer_sync_asserts (
   .clk_sys(clk_sys), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .paperDrive(paperDrive),
   .hammerFire(hammerFire), .irq(irq)
);

/* File: line_mem_model.sv */
// memory partner: answers word reads after a random delay
`timescale 1ns/1ps
module line_mem_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // word read channel
   input  wire logic        memReq,
   input  wire logic [14:0] memAddr,
   output logic             memAck,
   output logic [26:0]      memData,
   output logic             memAddrErr
);
   logic [1:0]  delayCnt;
   logic [24:0] body;
   assign memAddrErr = 1'b0;
   // characters from address; sign varies and must not matter
   always_comb begin
      body = {memAddr[0], 24'h0};
      for (int k = 0; k < 4; k++) begin
         body[23 - 6 * k -: 6] = 6'((memAddr * 5 + k * 11 + 3) & 6'h3F);
      end
   end
   // one word per request; idle data inverts so stale words fail
   always_ff @(posedge clk_sys) begin
      if (rst || memAck || !memReq) begin
         memAck <= 1'b0;
         delayCnt <= 2'($urandom);
         memData <= ~memData;
      end else if (delayCnt != 2'h0) begin
         delayCnt <= delayCnt - 2'h1;
         memData <= ~memData;
      end else begin
         memAck <= 1'b1;
         memData <= {2'(body % 3), body};
      end
   end
endmodule

/* File: tb_top.sv */
// self-checking bench for the line printer synchronizer
`timescale 1ns/1ps
module tb_top;
   import line_printer_sync_pkg::*;
   localparam int F = 20, L6 = 16, L8 = 12, ST = 20;
   logic         clk_sys = 0, rst = 1, ce = 1, faultPin = 0, paperMovingPin = 0;
   logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic         drumIndexPin = 0, drumRowPin = 0, eightLpiPin = 0, lowPaperPin = 0;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata, rd;
   logic [3:0]   wstrb = 4'hF;
   logic         awready, wready, bvalid, arready, rvalid, memReq, memAck, memAddrErr;
   logic         paperDrive, irq;
   logic [1:0]   bresp, rresp, rr;
   logic [14:0]  memAddr, addr;
   logic [5:0]   nLines;
   logic [26:0]  memData;
   logic [127:0] hammerFire;
   int           bad_count = 0, n_tests = 0, driveCycles = 0;
   int           strikes [128];
   line_printer_sync #(.FIRST_CNT(F), .LINE6_CNT(L6), .LINE8_CNT(L8), .SETTLE_CNT(ST),
      .RUNAWAY_CNT(5000)) i_line_printer_sync (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
      .memData(memData), .memAddrErr(memAddrErr), .drumIndexPin(drumIndexPin),
      .drumRowPin(drumRowPin), .eightLpiPin(eightLpiPin), .lowPaperPin(lowPaperPin),
      .faultPin(faultPin), .paperMovingPin(paperMovingPin), .paperDrive(paperDrive),
      .hammerFire(hammerFire), .irq(irq));
   line_mem_model i_line_mem_model (.clk_sys(clk_sys), .rst(rst), .memReq(memReq),
      .memAddr(memAddr), .memAck(memAck), .memData(memData), .memAddrErr(memAddrErr));
   initial forever #5 clk_sys = ~clk_sys;
   // drum: index mark for row 0, then one mark per further row
   initial forever begin
      for (int r = 0; r < DRUM_ROWS; r++) begin
         repeat (4) @(posedge clk_sys);
         if (r == 0) drumIndexPin <= 1'b1;
         else drumRowPin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         drumIndexPin <= 1'b0;
         drumRowPin <= 1'b0;
      end
   end
   // paper follows drive; tally drive cycles and strikes
   always @(posedge clk_sys) begin
      paperMovingPin <= paperDrive;
      if (paperDrive === 1'b1) driveCycles++;
      for (int c = 0; c < 128; c++) begin
         if (hammerFire[c] === 1'b1) strikes[c]++;
      end
   end
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rr = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   // command word with check pair; bits 25 and 17 zero
   function automatic logic [26:0] cmd(input logic [5:0] n, input logic p, i, input logic [14:0] a);
      logic [24:0] b;
      b = {1'b0, n, p, 1'b0, i, a};
      return {2'(b % 3), b};
   endfunction
   // a column strikes only if its code sits on the drum
   function automatic logic printable(input logic [14:0] a, input int c);
      logic [5:0] code;
      code = 6'(((a + 15'(c / 4)) * 5 + (c % 4) * 11 + 3) & 6'h3F);
      foreach (DRUM_CODES[i]) begin
         if (DRUM_CODES[i] == code) return 1'b1;
      end
      return 1'b0;
   endfunction
   task automatic wait_irq();
      for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk_sys);
      if (irq !== 1'b1) bad_count++;
   endtask
   task automatic start_line(input logic [5:0] n, input logic [14:0] a);
      driveCycles = 0;
      foreach (strikes[c]) strikes[c] = 0;
      eightLpiPin <= 1'($urandom);
      axi_wr(OFS_CMD, 32'(cmd(n, 1'b1, 1'b1, a)));
   endtask
   task automatic finish_line(input logic [5:0] n, input logic [14:0] a);
      int base;
      wait_irq();
      base = F + (n - 1) * (eightLpiPin ? L8 : L6);
      check(32'(driveCycles >= base && driveCycles <= base + n + 2), 32'h1);
      foreach (strikes[c]) check(32'(strikes[c]), 32'(printable(a, c)));
      axi_rd(OFS_STATUS);
      check(rd, 32'h1);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      end_sim();
   end
   initial begin
      void'($urandom(19));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      axi_rd(OFS_STATUS);
      check(rd, 32'h0);
      axi_rd(8'h10);
      check(32'(rr), 32'h2);
      axi_wr(8'h10, 32'h0);
      check(32'(rr), 32'h2);
      axi_wr(OFS_CTRL, 32'h1);
      addr = 15'($urandom);
      start_line(6'd3, addr);
      finish_line(6'd3, addr);
      // done still set: next command waits; address wraps
      start_line(6'd1, 15'h7FF0);
      repeat (100) @(posedge clk_sys);
      axi_rd(OFS_STATUS);
      check(rd, 32'h11);
      axi_wr(OFS_STATUS, 32'h1);
      finish_line(6'd1, 15'h7FF0);
      axi_wr(OFS_STATUS, 32'h1);
      // bad check pair, then no-print command under low paper
      driveCycles = 0;
      axi_wr(OFS_CMD, 32'(cmd(6'd2, 1'b1, 1'b1, 15'h0) ^ 27'h2000000));
      wait_irq();
      axi_rd(OFS_STATUS);
      check(rd, 32'h12);
      axi_wr(OFS_CMD, 32'(cmd(6'd0, 1'b0, 1'b0, 15'h0)));
      lowPaperPin <= 1'b1;
      axi_wr(OFS_STATUS, 32'h2);
      wait_irq();
      axi_rd(OFS_STATUS);
      check(rd, 32'h8);
      check(32'(driveCycles), 32'h0);
      addr = 15'($urandom);
      start_line(6'd2, addr);
      repeat (100) @(posedge clk_sys);
      axi_rd(OFS_STATUS);
      check(rd, 32'h18);
      lowPaperPin <= 1'b0;
      axi_wr(OFS_STATUS, 32'h8);
      finish_line(6'd2, addr);
      axi_wr(OFS_STATUS, 32'h1);
      repeat (2) begin
         nLines = 6'($urandom_range(4, 1));
         addr = 15'($urandom);
         start_line(nLines, addr);
         finish_line(nLines, addr);
         axi_wr(OFS_STATUS, 32'h1);
      end
      // mid-run reset
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      axi_rd(OFS_CTRL);
      check(rd, 32'h0);
      end_sim();
   end
endmodule
